// *** hw/usdp_pkg.sv ***
package usdp_pkg;
    // shadow data window: sixteen aliased word locations
    localparam logic [31:0] ALIAS_BASE = 32'h5000_1130;
    localparam logic [31:0] ALIAS_LAST = 32'h5000_116C;
    localparam logic [31:0] ALIAS_NINE = 32'h5000_1154;
    localparam logic [31:0] ALIAS_TEN = 32'h5000_1158;
    localparam int ALIAS_COUNT = 16;
    // control and status registers placed after the window
    localparam logic [31:0] REG_LINE_STATUS = 32'h5000_1170;
    localparam logic [31:0] REG_FIFO_CTRL = 32'h5000_1174;
    localparam logic [31:0] REG_MODE = 32'h5000_1178;
    localparam logic [31:0] REG_IRQ_STATUS = 32'h5000_117C;
    localparam logic [31:0] REG_IRQ_MASK = 32'h5000_1180;
    // field positions
    localparam int DATA_W = 8;
    localparam int LS_RX_AVAIL_BIT = 0;
    localparam int LS_OVERRUN_BIT = 1;
    localparam int LS_TX_EMPTY_BIT = 5;
    localparam int FIFO_CTRL_EN_BIT = 0;
    localparam int MODE_IR_BIT = 0;
    localparam int IRQ_BITS = 3;
    localparam int IRQ_RX_BIT = 0;
    localparam int IRQ_OVR_BIT = 1;
    localparam int IRQ_TX_EMPTY_BIT = 2;
    // reset values
    localparam logic FIFO_EN_RESET = 1'b0;
    localparam logic MODE_IR_RESET = 1'b0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // sizes
    localparam int FIFO_DEPTH_DEFAULT = 16;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // read path stages
    typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} usdp_rd_state_t;
endpackage

// *** hw/usdp_fifo_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// signals between the top and one of its character stores
interface usdp_fifo_if #(
    parameter int W = 8,
    parameter int CW = 5
);
    logic push;
    logic [W-1:0] push_data;
    logic pop;
    logic flush;
    logic [W-1:0] rd_data;
    logic full;
    logic empty;
    logic [CW-1:0] count;
    modport user (output push, push_data, pop, flush,
                  input rd_data, full, empty, count);
    modport store (input push, push_data, pop, flush,
                   output rd_data, full, empty, count);
endinterface
`default_nettype wire

// *** hw/usdp_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
// small character store; read data appear one cycle after pop
module usdp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic aclk,         // bus clock
    input wire logic aresetn,      // synchronous reset, active low
    usdp_fifo_if.store bus         // push, pop and status
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [W-1:0] rd_data;
    wire logic do_push = bus.push && !bus.full;
    wire logic do_pop = bus.pop && !bus.empty;

    ////////////////////////////////////////////////////////////////////
    // status; depth must be a power of two so the pointers wrap freely
    assign bus.full = (count == CW'(DEPTH));
    assign bus.empty = (count == '0);
    assign bus.count = count;
    assign bus.rd_data = rd_data;

    // storage array, no reset needed
    always_ff @(posedge aclk) begin
        if (do_push) begin
            mem[wr_ptr] <= bus.push_data;
        end
    end

    // pointers, occupancy and registered head data
    always_ff @(posedge aclk) begin
        if (!aresetn || bus.flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            rd_data <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + AW'(1);
                rd_data <= mem[rd_ptr];
            end
            count <= count + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule
`default_nettype wire

// *** hw/usdp_top.sv ***
// Operation
// RULE1: sixteen consecutive word locations all reach the same data port.
// RULE2: reading returns the received byte, serial or infrared input by mode.
// RULE3: read data are valid only while the byte-available flag is set.
// RULE4: without FIFOs a new byte overwrites an unread one and flags overrun.
// RULE5: with FIFOs a read returns and removes the oldest receive entry.
// RULE6: full receive FIFO keeps contents, drops new byte, flags overrun.
// RULE7: a write queues a byte for serial or infrared output by mode.
// RULE8: software writes only while the holding-empty flag is set.
// RULE9: without FIFOs a single write clears the holding-empty flag.
// RULE10: without FIFOs further writes overwrite the pending holding byte.
// RULE11: with FIFOs writes are accepted up to the configured depth.
// RULE12: a write while the transmit FIFO is full is discarded.
// RULE13: bits above the byte read as zero and ignore writes.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module usdp_top #(
    parameter int FIFO_DEPTH = usdp_pkg::FIFO_DEPTH_DEFAULT
) (
    input wire logic aclk,              // bus clock, 125 MHz
    input wire logic aresetn,           // synchronous reset, active low
    input wire logic [31:0] awaddr,     // write address
    input wire logic [2:0] awprot,      // unused protection
    input wire logic awvalid,           // write address valid
    output logic awready,               // write address ready
    input wire logic [31:0] wdata,      // write data
    input wire logic [3:0] wstrb,       // byte lanes
    input wire logic wvalid,            // write data valid
    output logic wready,                // write data ready
    output logic [1:0] bresp,           // write answer
    output logic bvalid,                // write answer valid
    input wire logic bready,            // write answer ready
    input wire logic [31:0] araddr,     // read address
    input wire logic [2:0] arprot,      // unused protection
    input wire logic arvalid,           // read address valid
    output logic arready,               // read address ready
    output logic [31:0] rdata,          // read data
    output logic [1:0] rresp,           // read answer
    output logic rvalid,                // read answer valid
    input wire logic rready,            // read answer ready
    input wire logic rx_ser_valid,      // byte done on serial input
    input wire logic [7:0] rx_ser_char, // serial input byte
    input wire logic rx_ir_valid,       // byte done on infrared input
    input wire logic [7:0] rx_ir_char,  // infrared input byte
    output logic [7:0] tx_char,         // byte offered to the transmitter
    output logic tx_ser_valid,          // byte for serial output
    output logic tx_ir_valid,           // byte for infrared encoder
    input wire logic tx_char_ready,     // transmitter takes the byte
    output logic irq                    // level interrupt
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    usdp_fifo_if #(.W(usdp_pkg::DATA_W), .CW(CW)) rx_if();
    usdp_fifo_if #(.W(usdp_pkg::DATA_W), .CW(CW)) tx_if();

    logic [31:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic fifo_en;
    logic mode_ir;
    logic overrun;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [7:0] rx_hold;
    logic rx_hold_valid;
    logic [7:0] tx_hold;
    logic tx_hold_valid;
    logic tx_pop_pend;
    logic tx_empty_q;
    logic rd_from_fifo;
    logic [31:0] rd_value;
    logic [1:0] rd_resp;
    usdp_pkg::usdp_rd_state_t rd_state;

    // shadow window decode, shared by read and write paths
    function automatic logic is_alias(input logic [31:0] a);
        return (a >= usdp_pkg::ALIAS_BASE) && (a <= usdp_pkg::ALIAS_LAST)
            && (a[1:0] == 2'h0);
    endfunction

    function automatic logic is_mapped(input logic [31:0] a);
        return is_alias(a) || (a == usdp_pkg::REG_LINE_STATUS)
            || (a == usdp_pkg::REG_FIFO_CTRL) || (a == usdp_pkg::REG_MODE)
            || (a == usdp_pkg::REG_IRQ_STATUS)
            || (a == usdp_pkg::REG_IRQ_MASK);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus strobes
    wire logic rd_fire = arvalid && arready;
    wire logic wr_fire = !awready && !wready && !bvalid;
    wire logic rd_alias = is_alias(araddr);                  // RULE1
    wire logic wr_alias = is_alias(aw_addr);                 // RULE1
    wire logic rd_lsr = rd_fire && (araddr == usdp_pkg::REG_LINE_STATUS);
    wire logic rd_irq = rd_fire && (araddr == usdp_pkg::REG_IRQ_STATUS);
    wire logic wr_tx = wr_fire && wr_alias && w_lane0;
    wire logic wr_fcr = wr_fire && w_lane0
        && (aw_addr == usdp_pkg::REG_FIFO_CTRL);
    wire logic wr_mode = wr_fire && w_lane0
        && (aw_addr == usdp_pkg::REG_MODE);
    wire logic wr_mask = wr_fire && w_lane0
        && (aw_addr == usdp_pkg::REG_IRQ_MASK);
    wire logic new_fifo_en = w_data[usdp_pkg::FIFO_CTRL_EN_BIT];
    // switching FIFO enable empties both paths so no byte straddles the modes
    wire logic flush = wr_fcr && (new_fifo_en != fifo_en);

    // receive side selection and events
    wire logic rx_in_valid = mode_ir ? rx_ir_valid : rx_ser_valid;
    wire logic [7:0] rx_in_char = mode_ir ? rx_ir_char : rx_ser_char;
    wire logic rd_alias_pop = rd_fire && rd_alias && fifo_en
        && !rx_if.empty;                                     // RULE5
    wire logic rd_alias_hold = rd_fire && rd_alias && !fifo_en;
    wire logic rx_push = rx_in_valid && fifo_en && !rx_if.full;
    wire logic rx_ovr = rx_in_valid && (fifo_en ? rx_if.full
        : (rx_hold_valid && !rd_alias_hold));                // RULE4 RULE6
    wire logic rx_byte_available = fifo_en ? !rx_if.empty
        : rx_hold_valid;                                     // RULE3

    // transmit side
    wire logic tx_holding_empty = fifo_en ? tx_if.empty : !tx_hold_valid;
    wire logic slot_full = tx_ser_valid || tx_ir_valid;
    wire logic slot_taken = slot_full && tx_char_ready;
    wire logic load_ok = !slot_full && !tx_pop_pend;
    wire logic tx_pop = load_ok && fifo_en && !tx_if.empty;
    wire logic tx_hold_load = load_ok && !fifo_en && tx_hold_valid;
    wire logic tx_push = wr_tx && fifo_en;                   // RULE11 RULE12

    // status word and interrupt events
    wire logic [31:0] line_status_reg =
        (32'(rx_byte_available) << usdp_pkg::LS_RX_AVAIL_BIT)
        | (32'(overrun) << usdp_pkg::LS_OVERRUN_BIT)
        | (32'(tx_holding_empty) << usdp_pkg::LS_TX_EMPTY_BIT);
    wire logic [2:0] irq_events =
        (3'(rx_push || (rx_in_valid && !fifo_en)) << usdp_pkg::IRQ_RX_BIT)
        | (3'(rx_ovr) << usdp_pkg::IRQ_OVR_BIT)
        | (3'(tx_holding_empty && !tx_empty_q)
        << usdp_pkg::IRQ_TX_EMPTY_BIT);
    // a read clears, an event in the same cycle survives it
    wire logic [2:0] next_irq_status =
        (irq_status & ~(rd_irq ? 3'h7 : 3'h0)) | irq_events;
    wire logic next_overrun = (overrun && !rd_lsr) || rx_ovr;

    // store connections; the store itself drops pushes when full
    assign rx_if.push = rx_push;
    assign rx_if.push_data = rx_in_char;
    assign rx_if.pop = rd_alias_pop;
    assign rx_if.flush = flush;
    assign tx_if.push = tx_push;
    assign tx_if.push_data = w_data;
    assign tx_if.pop = tx_pop;
    assign tx_if.flush = flush;

    usdp_fifo #(.W(usdp_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus(rx_if)
    );

    usdp_fifo #(.W(usdp_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus(tx_if)
    );

    // read value chosen at address acceptance
    logic [31:0] read_word;
    always_comb begin
        read_word = 32'h0;
        if (rd_alias) begin
            read_word = (!fifo_en && rx_hold_valid) ? {24'h0, rx_hold}
                : 32'h0;                                     // RULE2 RULE13
        end else if (araddr == usdp_pkg::REG_LINE_STATUS) begin
            read_word = line_status_reg;
        end else if (araddr == usdp_pkg::REG_FIFO_CTRL) begin
            read_word = 32'(fifo_en) << usdp_pkg::FIFO_CTRL_EN_BIT;
        end else if (araddr == usdp_pkg::REG_MODE) begin
            read_word = 32'(mode_ir) << usdp_pkg::MODE_IR_BIT;
        end else if (araddr == usdp_pkg::REG_IRQ_STATUS) begin
            read_word = {29'h0, irq_status};
        end else if (araddr == usdp_pkg::REG_IRQ_MASK) begin
            read_word = {29'h0, irq_mask};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write channels; address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= usdp_pkg::RESP_OKAY;
            aw_addr <= 32'h0;
            w_data <= usdp_pkg::DATA_RESET;
            w_lane0 <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data <= wdata[7:0];                        // RULE13
                w_lane0 <= wstrb[0];
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= is_mapped(aw_addr) ? usdp_pkg::RESP_OKAY
                    : usdp_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // read channels: accept, fetch, answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= usdp_pkg::RESP_OKAY;
            rd_state <= usdp_pkg::RD_IDLE;
            rd_from_fifo <= 1'b0;
            rd_value <= 32'h0;
            rd_resp <= usdp_pkg::RESP_OKAY;
        end else begin
            case (rd_state)
                usdp_pkg::RD_IDLE: begin
                    if (rd_fire) begin
                        arready <= 1'b0;
                        rd_from_fifo <= rd_alias_pop;
                        rd_value <= read_word;
                        rd_resp <= is_mapped(araddr) ? usdp_pkg::RESP_OKAY
                            : usdp_pkg::RESP_SLVERR;
                        rd_state <= usdp_pkg::RD_FETCH;
                    end
                end
                usdp_pkg::RD_FETCH: begin
                    // popped head is only valid one cycle after the pop
                    rdata <= rd_from_fifo ? {24'h0, rx_if.rd_data}
                        : rd_value;                          // RULE5
                    rresp <= rd_resp;
                    rvalid <= 1'b1;
                    rd_state <= usdp_pkg::RD_RESP;
                end
                default: begin
                    if (rready) begin
                        rvalid <= 1'b0;
                        arready <= 1'b1;
                        rd_state <= usdp_pkg::RD_IDLE;
                    end
                end
            endcase
        end
    end

    // control registers, flags and interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifo_en <= usdp_pkg::FIFO_EN_RESET;
            mode_ir <= usdp_pkg::MODE_IR_RESET;
            irq_mask <= usdp_pkg::IRQ_MASK_RESET;
            irq_status <= 3'h0;
            overrun <= 1'b0;
            tx_empty_q <= 1'b1;
            irq <= 1'b0;
        end else begin
            if (wr_fcr) begin
                fifo_en <= new_fifo_en;
            end
            if (wr_mode) begin
                mode_ir <= w_data[usdp_pkg::MODE_IR_BIT];
            end
            if (wr_mask) begin
                irq_mask <= w_data[2:0];
            end
            irq_status <= next_irq_status;
            overrun <= next_overrun;                         // RULE4 RULE6
            tx_empty_q <= tx_holding_empty;
            irq <= |(next_irq_status & irq_mask);
        end
    end

    // single receive holding byte for the no-FIFO mode
    always_ff @(posedge aclk) begin
        if (!aresetn || flush) begin
            rx_hold <= usdp_pkg::DATA_RESET;
            rx_hold_valid <= 1'b0;
        end else if (rx_in_valid && !fifo_en) begin
            rx_hold <= rx_in_char;                           // RULE2 RULE4
            rx_hold_valid <= 1'b1;
        end else if (rd_alias_hold) begin
            rx_hold_valid <= 1'b0;
        end
    end

    // transmit holding byte; a late write simply replaces it
    always_ff @(posedge aclk) begin
        if (!aresetn || flush) begin
            tx_hold <= usdp_pkg::DATA_RESET;
            tx_hold_valid <= 1'b0;
        end else if (wr_tx && !fifo_en) begin
            tx_hold <= w_data;                               // RULE10
            tx_hold_valid <= 1'b1;                           // RULE9
        end else if (tx_hold_load) begin
            tx_hold_valid <= 1'b0;
        end
    end

    // output slot toward the transmitter, routed by the mode at load
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_char <= usdp_pkg::DATA_RESET;
            tx_ser_valid <= 1'b0;
            tx_ir_valid <= 1'b0;
            tx_pop_pend <= 1'b0;
        end else begin
            tx_pop_pend <= tx_pop;
            if (tx_pop_pend || tx_hold_load) begin
                tx_char <= tx_pop_pend ? tx_if.rd_data : tx_hold;
                tx_ser_valid <= !mode_ir;                    // RULE7
                tx_ir_valid <= mode_ir;                      // RULE7
            end else if (slot_taken) begin
                tx_ser_valid <= 1'b0;
                tx_ir_valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_hold_read;
        rd_alias_hold && rx_hold_valid;
    endsequence

    sequence s_answer_two;
        ##2 rvalid;
    endsequence

    chk_alias_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_alias |-> s_answer_two ##0 (rresp == 2'h0)) // RULE1
        else $error("alias read not answered okay");
    chk_hold_data: assert property (@(posedge aclk) disable iff (!aresetn)
        s_hold_read |-> s_answer_two ##0
        (rdata[7:0] == $past(rx_hold, 2)))                   // RULE2
        else $error("alias read lost holding byte");
    chk_empty_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_alias && !rx_byte_available
        |-> ##2 (rdata == 32'h0))                            // RULE3
        else $error("empty read not zero");
    chk_rx_overrun: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_in_valid && !fifo_en && rx_hold_valid && !rd_alias_hold
        |=> overrun && (rx_hold == $past(rx_in_char)))       // RULE4
        else $error("overwrite without overrun");
    chk_fifo_pop: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_alias_pop && !rx_push && !flush
        |=> rx_if.count == $past(rx_if.count) - CW'(1))      // RULE5
        else $error("read did not pop");
    chk_full_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_in_valid && fifo_en && rx_if.full && !rd_alias_pop && !flush
        |=> overrun && $stable(rx_if.count))                 // RULE6
        else $error("full receive store changed");
    chk_tx_route: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(tx_ser_valid || tx_ir_valid)
        |-> (tx_ir_valid == $past(mode_ir)) && !(tx_ser_valid && tx_ir_valid))
        else $error("byte routed to wrong output");          // RULE7
    chk_empty_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_tx && !fifo_en && tx_holding_empty && !wr_fcr
        |=> !tx_holding_empty)                               // RULE9
        else $error("write left holding empty set");
    chk_hold_over: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_tx && !fifo_en && !wr_fcr |=> tx_hold == $past(w_data)) // RULE10
        else $error("holding byte not replaced");
    chk_fifo_accept: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_push && !tx_if.full && !tx_pop && !flush
        |=> tx_if.count == $past(tx_if.count) + CW'(1))      // RULE11
        else $error("write not queued");
    chk_tx_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_push && tx_if.full && !tx_pop && !flush
        |=> $stable(tx_if.count))                            // RULE12
        else $error("full transmit store changed");
    chk_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_alias |-> ##2 (rdata[31:8] == 24'h0))  // RULE13
        else $error("reserved bits not zero");
endmodule
`default_nettype wire

// *** testbench/usdp_xcvr_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// far transceiver: feeds received bytes, takes bytes to send
module usdp_xcvr_model (
    input wire logic aclk, // bus clock
    input wire logic stall, // hold off taking bytes
    output logic rx_ser_valid, // serial byte strobe
    output logic [7:0] rx_ser_char, // serial byte
    output logic rx_ir_valid, // infrared byte strobe
    output logic [7:0] rx_ir_char, // infrared byte
    input wire logic [7:0] tx_char, // offered byte
    input wire logic tx_ser_valid, // serial byte offered
    input wire logic tx_ir_valid, // infrared byte offered
    output logic tx_char_ready // byte taken
);
    logic [8:0] got[$];
    initial begin
        rx_ser_valid = 1'b0;
        rx_ir_valid = 1'b0;
        rx_ser_char = 8'h00;
        rx_ir_char = 8'h00;
    end
    // one-cycle strobe; lines show the inverse outside it so stale bytes fail
    task automatic send(input logic ir, input logic [7:0] b);
        rx_ser_valid <= !ir;
        rx_ir_valid <= ir;
        rx_ser_char <= b;
        rx_ir_char <= b;
        @(posedge aclk);
        rx_ser_valid <= 1'b0;
        rx_ir_valid <= 1'b0;
        rx_ser_char <= ~b;
        rx_ir_char <= ~b;
        @(posedge aclk);
    endtask
    assign tx_char_ready = !stall;
    // log each byte taken, with the infrared route in bit 8
    always @(posedge aclk) begin
        if ((tx_ser_valid || tx_ir_valid) && tx_char_ready) got.push_back({tx_ir_valid, tx_char});
    end
endmodule
`default_nettype wire

// *** testbench/usdp_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module usdp_top_tb;
    localparam logic [31:0] AB = usdp_pkg::ALIAS_BASE;
    localparam logic [31:0] LS = usdp_pkg::REG_LINE_STATUS;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, stall = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, irq, txs, txi, txr, rs, ri;
    logic [7:0] rs_c, ri_c, tx_char;
    logic [1:0] bresp, rresp;
    int err_total = 0, compares = 0, cycles = 0;
    usdp_top #(.FIFO_DEPTH(4)) usdp_top_i (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_ser_valid(rs),
        .rx_ser_char(rs_c), .rx_ir_valid(ri), .rx_ir_char(ri_c),
        .tx_char(tx_char), .tx_ser_valid(txs), .tx_ir_valid(txi),
        .tx_char_ready(txr), .irq(irq));
    usdp_xcvr_model usdp_xcvr_model_i (.aclk(aclk), .stall(stall),
        .rx_ser_valid(rs), .rx_ser_char(rs_c), .rx_ir_valid(ri),
        .rx_ir_char(ri_c), .tx_char(tx_char), .tx_ser_valid(txs),
        .tx_ir_valid(txi), .tx_char_ready(txr));
    always #4 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // both channels offered together, each released when taken
    task automatic wr(input logic [31:0] a, d, input logic [1:0] r = 2'h0);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, r});
    endtask
    task automatic rd(input logic [31:0] a, e, input logic [1:0] r = 2'h0);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, r});
    endtask
    function automatic logic [31:0] nxt();
        return 32'(usdp_xcvr_model_i.got.pop_front());
    endfunction
    task automatic finish_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard: far above the few hundred cycles the run needs
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(LS, 32'h20);
        rd(usdp_pkg::ALIAS_NINE, 32'h0);
        rd(32'h5000_1000, 32'h0, 2'h2);
        wr(usdp_pkg::REG_IRQ_MASK, 32'h1);
        usdp_xcvr_model_i.send(1'b0, 8'hA5);
        usdp_xcvr_model_i.send(1'b0, 8'h3C);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rd(LS, 32'h23);
        wr(usdp_pkg::REG_IRQ_MASK, 32'h0);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd(usdp_pkg::REG_IRQ_STATUS, 32'h3);
        rd(usdp_pkg::REG_IRQ_STATUS, 32'h0);
        rd(usdp_pkg::ALIAS_TEN, 32'h3C);
        rd(LS, 32'h20);
        $display("receive without store done");
        wr(usdp_pkg::REG_FIFO_CTRL, 32'h1);
        for (int i = 0; i < 5; i++) usdp_xcvr_model_i.send(1'b0, 8'(16 + i));
        for (int i = 0; i < 4; i++) rd(AB + 32'(4 * i), 32'(16 + i));
        rd(LS, 32'h22);
        $display("receive store done");
        // stalled far side: one byte in the slot, four stored, rest lost
        stall <= 1'b1;
        for (int i = 0; i < 7; i++) wr(AB + 32'(8 * i), 32'hFF40 + 32'(i));
        rd(LS, 32'h0);
        stall <= 1'b0;
        repeat (40) @(posedge aclk);
        chk(32'(usdp_xcvr_model_i.got.size()), 32'h5);
        for (int i = 0; i < 5; i++) chk(nxt(), 32'h40 + 32'(i));
        rd(usdp_pkg::REG_IRQ_STATUS, 32'h7);
        $display("transmit store done");
        wr(usdp_pkg::REG_FIFO_CTRL, 32'h0);
        stall <= 1'b1;
        wr(AB, 32'h71);
        wr(AB + 32'h4, 32'h72);
        rd(LS, 32'h0);
        wr(AB + 32'h8, 32'h73);
        stall <= 1'b0;
        repeat (20) @(posedge aclk);
        chk(nxt(), 32'h71);
        chk(nxt(), 32'h73);
        $display("transmit hold done");
        wr(usdp_pkg::REG_MODE, 32'h1);
        usdp_xcvr_model_i.send(1'b1, 8'hC7);
        usdp_xcvr_model_i.send(1'b0, 8'h11);
        rd(AB + 32'h3C, 32'hC7);
        wr(AB, 32'h5A);
        repeat (10) @(posedge aclk);
        chk(nxt(), 32'h15A);
        $display("infrared done");
        finish_test();
    end
endmodule
`default_nettype wire
